//--- dmw_pkg.sv
/*
  Constants for the deadman watchdog: register indices, field layout,
  reset values and the one-second timebase count.
  Assumes a 250 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package dmw_pkg;
  // Register indices; byte address is four times the index
  localparam logic [29:0] DMW_IDX_CTRL = 30'h0B0000E0;
  localparam logic [29:0] DMW_IDX_TMO = 30'h0B0000E2;
  localparam logic [29:0] DMW_IDX_CLR = 30'h0B0000E4;
  localparam logic [29:0] DMW_IDX_ELAPSED = 30'h0B0000E6;
  localparam logic [29:0] DMW_IDX_IRQ_STS = 30'h0B0000E8;
  localparam logic [29:0] DMW_IDX_IRQ_MASK = 30'h0B0000EA;

  // Field positions and widths
  localparam int DMW_EN_BIT = 0;
  localparam int DMW_CLR_BIT = 0;
  localparam int DMW_SEC_W = 4;
  localparam int DMW_EVT_TIMEOUT = 0;
  localparam int DMW_EVT_W = 1;

  // Reset values
  localparam logic DMW_EN_RST = 1'b0;
  localparam logic [3:0] DMW_TMO_RST = 4'h0;
  localparam logic [3:0] DMW_SEC_RST = 4'h0;
  localparam logic [0:0] DMW_MASK_RST = 1'h0;

  // Timebase: one second at the system clock rate
  localparam int unsigned DMW_TICK_MS = 1000;
  localparam int unsigned DMW_CLK_KHZ = 250000;
  localparam int unsigned DMW_TICK_CYC = DMW_TICK_MS * DMW_CLK_KHZ;

  // Length of the processor reset request in clock cycles
  localparam int unsigned DMW_RST_HOLD = 16;
endpackage

//--- dmw_top.sv
/*
  Deadman watchdog: AHB-Lite register slave, one-second timebase,
  elapsed-seconds counter, processor reset request and interrupt.
  Assumes a single 250 MHz clock, a single AHB-Lite master doing only
  word-sized single transfers, and that inputs are synchronous to mclk.
*/
// The AHB-Lite interface to the registers is this design's own decision.
// Function
// - Elapsed seconds shown in low four bits
// - Elapsed register upper bits read as zero
// - Missed clear in time resets the processor
// - Read returns current elapsed seconds value
// - Control bit zero enables, resets to zero
// - Writing one to clear restarts counter
`timescale 1ns/1ps
module dmw_top #(
  parameter int unsigned TICK_CYCLES = dmw_pkg::DMW_TICK_CYC,
  parameter int unsigned RST_HOLD = dmw_pkg::DMW_RST_HOLD
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic cpu_reset_req,
  output logic irq
);
  import dmw_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int HOLD_W = $clog2(RST_HOLD + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RST_HOLD);

  logic [1:0] rst_sync_q; // Reset release synchroniser
  logic rst_n; // Synchronised reset
  logic wr_q; // Write data phase pending
  logic [29:0] widx_q; // Register index of pending write
  logic [31:0] hrdata_q; // Read data for the data phase
  logic addr_ok; // Address phase accepted this cycle
  logic en_q; // Watchdog enable bit
  logic [3:0] tmo_q; // Timeout seconds
  logic [3:0] sec_q; // Elapsed seconds
  logic [DIV_W-1:0] div_q; // One-second divider
  logic tick; // One-cycle pulse per second
  logic kick; // Software clear strobe
  logic fire; // Timeout reached this cycle
  logic [4:0] sec_inc; // Elapsed seconds plus one
  logic [HOLD_W-1:0] hold_q; // Reset request hold counter
  logic rst_req_q; // Registered reset request
  logic [DMW_EVT_W-1:0] sts_q; // Sticky event status
  logic [DMW_EVT_W-1:0] mask_q; // Interrupt mask
  logic [31:0] rmux; // Read data selected by address
  logic we_ctrl, we_tmo, we_clr, we_sts, we_mask; // Write strobes

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Slave always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;

  // Address phase capture for writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      widx_q <= 30'h0;
    end else begin
      wr_q <= addr_ok && hwrite;
      widx_q <= haddr[31:2];
    end
  end

  // Write strobes during the data phase
  assign we_ctrl = wr_q && (widx_q == DMW_IDX_CTRL);
  assign we_tmo = wr_q && (widx_q == DMW_IDX_TMO);
  assign we_clr = wr_q && (widx_q == DMW_IDX_CLR);
  assign we_sts = wr_q && (widx_q == DMW_IDX_IRQ_STS);
  assign we_mask = wr_q && (widx_q == DMW_IDX_IRQ_MASK);
  assign kick = we_clr && hwdata[DMW_CLR_BIT];

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rmux = 32'h0;
    unique case (haddr[31:2])
      DMW_IDX_CTRL: rmux[DMW_EN_BIT] = en_q;
      DMW_IDX_TMO: rmux[DMW_SEC_W-1:0] = tmo_q;
      DMW_IDX_ELAPSED: rmux[DMW_SEC_W-1:0] = sec_q;
      DMW_IDX_IRQ_STS: rmux[DMW_EVT_W-1:0] = sts_q;
      DMW_IDX_IRQ_MASK: rmux[DMW_EVT_W-1:0] = mask_q;
      default: rmux = 32'h0;
    endcase
  end

  // Read data registered at the address phase edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata_q <= rmux;
    end
  end
  assign hrdata = hrdata_q;

  // Enable bit; only bit 0 is stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= DMW_EN_RST;
    end else if (we_ctrl) begin
      en_q <= hwdata[DMW_EN_BIT];
    end
  end

  // Timeout seconds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_q <= DMW_TMO_RST;
    end else if (we_tmo) begin
      tmo_q <= hwdata[DMW_SEC_W-1:0];
    end
  end

  // One-second divider, restarted by clear or disable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (!en_q || kick || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end
  assign tick = en_q && (div_q == DIV_LAST);

  // Timeout when the next second reaches the programmed value
  assign sec_inc = {1'b0, sec_q} + 5'h01;
  assign fire = tick && !kick && (sec_inc >= {1'b0, tmo_q});

  // Elapsed seconds counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sec_q <= DMW_SEC_RST;
    end else if (!en_q || kick) begin
      sec_q <= 4'h0;
    end else if (fire) begin
      sec_q <= 4'h0;
    end else if (tick) begin
      sec_q <= sec_inc[3:0];
    end
  end

  // Processor reset request held for a fixed number of cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
      rst_req_q <= 1'b0;
    end else if (fire) begin
      hold_q <= HOLD_LOAD - HOLD_W'(1);
      rst_req_q <= 1'b1;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - HOLD_W'(1);
    end else begin
      rst_req_q <= 1'b0;
    end
  end
  assign cpu_reset_req = rst_req_q;

  // Sticky timeout status; a new event wins over a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= '0;
    end else begin
      sts_q[DMW_EVT_TIMEOUT] <= fire || (sts_q[DMW_EVT_TIMEOUT] &&
        !(we_sts && hwdata[DMW_EVT_TIMEOUT]));
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= DMW_MASK_RST;
    end else if (we_mask) begin
      mask_q <= hwdata[DMW_EVT_W-1:0];
    end
  end

  // Level interrupt while an unmasked status bit is set
  assign irq = |(sts_q & mask_q);

  // Reserved bits of an elapsed-time read come back zero
  property p_rsv_zero;
    @(posedge mclk) disable iff (!rst_n)
      (addr_ok && !hwrite && haddr[31:2] == DMW_IDX_ELAPSED)
        |=> (hrdata[31:4] == 28'h0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("elapsed read upper bits not zero");

  // Elapsed read returns the count seen at the address phase
  property p_read_sec;
    @(posedge mclk) disable iff (!rst_n)
      (addr_ok && !hwrite && haddr[31:2] == DMW_IDX_ELAPSED)
        |=> (hrdata[3:0] == $past(sec_q));
  endproperty
  a_read_sec: assert property (p_read_sec)
    else $error("elapsed read data wrong");

  // Elapsed never passes a nonzero timeout while enabled
  property p_sec_range;
    @(posedge mclk) disable iff (!rst_n)
      (en_q && tmo_q != 4'h0 && !$changed(tmo_q)) |-> (sec_q < tmo_q);
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("elapsed reached timeout without reset");

  // Reaching the timeout raises the reset and restarts the count
  property p_fire;
    @(posedge mclk) disable iff (!rst_n)
      (en_q && tick && !kick && sec_inc >= {1'b0, tmo_q})
        |=> (cpu_reset_req && sec_q == 4'h0) [*2];
  endproperty
  a_fire: assert property (p_fire)
    else $error("timeout did not reset processor");

  // Control write sets the enable from bit 0
  property p_ctrl;
    @(posedge mclk) disable iff (!rst_n)
      we_ctrl |=> (en_q == $past(hwdata[0]));
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("enable bit not written");

  // Clear of one zeroes the count; clear of zero leaves it alone
  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
      we_clr |=> ($past(hwdata[0]) ? sec_q == 4'h0 :
        ($past(tick || !en_q) || sec_q == $past(sec_q)));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear write misbehaved");

  // One second without clear or timeout adds exactly one
  property p_count;
    @(posedge mclk) disable iff (!rst_n)
      (tick && !kick && !fire) |=> (sec_q == $past(sec_inc[3:0]));
  endproperty
  a_count: assert property (p_count)
    else $error("elapsed count did not advance");

  // Disabled watchdog holds zero and never fires
  property p_disabled;
    @(posedge mclk) disable iff (!rst_n)
      !en_q |=> (sec_q == 4'h0 && !$rose(cpu_reset_req));
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled watchdog counted or fired");
endmodule

//--- tb_dmw_top.sv
/*
  Self-checking bench for the deadman watchdog over AHB-Lite.
  Assumes dmw_pkg and dmw_top are compiled first; one 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_dmw_top;
  import dmw_pkg::*;
  localparam int TK = 20; // Short second for simulation
  localparam logic [31:0] A_CTL = {DMW_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_TMO = {DMW_IDX_TMO, 2'b00};
  localparam logic [31:0] A_CLR = {DMW_IDX_CLR, 2'b00};
  localparam logic [31:0] A_ELP = {DMW_IDX_ELAPSED, 2'b00};
  localparam logic [31:0] A_STS = {DMW_IDX_IRQ_STS, 2'b00};
  localparam logic [31:0] A_MSK = {DMW_IDX_IRQ_MASK, 2'b00};
  logic mclk, rstn, hsel, hwrite, hreadyout, hresp, cpu_reset_req, irq;
  logic [1:0] htrans; // Transfer type
  logic [2:0] hsize; // Always word
  logic [31:0] haddr, hwdata, hrdata, rd;
  int rst_cnt, rst_base; // Reset-request cycles seen, and a snapshot
  int failures, checks, n;

  dmw_top #(.TICK_CYCLES(TK), .RST_HOLD(16)) u_dmw_top (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .cpu_reset_req(cpu_reset_req), .irq(irq));

  // Free-running clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Count cycles with the reset request high
  always @(posedge mclk) begin
    if (cpu_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait for hready at a rising edge, bounded
  task automatic wrdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (hreadyout === 1'b1) return;
    end
    failures++;
    report_and_stop();
  endtask

  task automatic wr(input logic [31:0] a, d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wrdy();
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, e);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wrdy();
    htrans <= 2'h0;
    wrdy();
    chk(nm, e, hrdata);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rst_base = 0;
    failures = 0;
    checks = 0;
    cyc(5);
    rstn <= 1'b1;
    cyc(4);
    rdchk("ctrl", A_CTL, 32'h0);
    rdchk("tmo", A_TMO, 32'h0);
    rdchk("elapsed", A_ELP, 32'h0);
    rdchk("mask", A_MSK, 32'h0);
    rdchk("unmapped", A_CTL + 32'h40, 32'h0);
    chk("rst_req", 32'h0, {31'h0, cpu_reset_req});
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
    for (n = 1; n < 16; n++) begin
      wr(A_TMO, 32'(n));
      rdchk("tmo", A_TMO, 32'(n));
    end
    wr(A_CTL, 32'h0000FFFF);
    rdchk("ctrl", A_CTL, 32'h1);
    wr(A_CTL, 32'h0);
    wr(A_ELP, 32'h0000000F);
    rdchk("elapsed", A_ELP, 32'h0);
    rdchk("clear", A_CLR, 32'h0);
    $display("test registers done");
    wr(A_CTL, 32'h1);
    wr(A_CLR, 32'h1);
    cyc(2 * TK + 7);
    rdchk("elapsed", A_ELP, 32'h2);
    wr(A_CLR, 32'h0);
    rdchk("elapsed", A_ELP, 32'h2);
    wr(A_CLR, 32'h1);
    rdchk("elapsed", A_ELP, 32'h0);
    cyc(TK + 5);
    rdchk("elapsed", A_ELP, 32'h1);
    $display("test counting done");
    wr(A_CTL, 32'h0);
    wr(A_TMO, 32'h2);
    rst_base = rst_cnt;
    wr(A_CTL, 32'h1);
    wr(A_CLR, 32'h1);
    repeat (4) begin
      cyc(28);
      wr(A_CLR, 32'h1);
    end
    chk("no_reset", 32'(rst_base), 32'(rst_cnt));
    $display("test servicing done");
    wr(A_MSK, 32'h1);
    wr(A_CLR, 32'h1);
    n = 0;
    while (cpu_reset_req !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    rd = 32'(n >= 2 * TK - 3 && n <= 2 * TK + 3);
    chk("latency_ok", 32'h1, rd);
    chk("irq", 32'h1, {31'h0, irq});
    n = 1;
    while (n < 40) begin
      @(posedge mclk);
      #1;
      if (cpu_reset_req !== 1'b1) break;
      n++;
    end
    chk("hold", 32'd16, 32'(n));
    wr(A_CTL, 32'h0);
    wr(A_MSK, 32'h0);
    #1 chk("irq_masked", 32'h0, {31'h0, irq});
    wr(A_MSK, 32'h1);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rdchk("status", A_STS, 32'h1);
    wr(A_STS, 32'h1);
    #1 chk("irq_clr", 32'h0, {31'h0, irq});
    rdchk("status", A_STS, 32'h0);
    $display("test timeout done");
    rst_base = rst_cnt;
    cyc(3 * TK);
    rdchk("elapsed", A_ELP, 32'h0);
    chk("no_reset", 32'(rst_base), 32'(rst_cnt));
    $display("test disabled done");
    report_and_stop();
  end
endmodule
